// *** common/pesc_cfg.svh ***
// Constants for the advanced status and statistics register bank.
// Assumes inclusion by bare name from package and design files.
`ifndef PESC_CFG_SVH
`define PESC_CFG_SVH

// ----------------------------------------
// Advanced register indices
// ----------------------------------------
`define PESC_IDX_W          4
`define PESC_IDX_STAT_ONE   4'h0
`define PESC_IDX_STAT_TWO   4'h1
`define PESC_IDX_GOOD_HIGH  4'h2
`define PESC_IDX_GOOD_MID   4'h3
`define PESC_IDX_GOOD_LOW   4'h4
`define PESC_IDX_FCS_HIGH   4'h5
`define PESC_IDX_FCS_MID    4'h6
`define PESC_IDX_FCS_LOW    4'h7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PESC_S1_PLL_BIT     15
`define PESC_S1_POL_HI      14
`define PESC_S1_POL_LO      11
`define PESC_S1_REFCLK_BIT  8
`define PESC_S2_XOVER01_BIT 15
`define PESC_S2_XOVER23_BIT 14
`define PESC_S2_SPDOPT_BIT  13

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define PESC_REG_W          16
`define PESC_CNT_W          48
`define PESC_REG_RESET      16'h0000
`define PESC_SYNC_W         3

`endif

// *** common/pesc_pkg.sv ***
// Types for the advanced status and statistics register bank.
// Assumes pesc_cfg.svh is on the include path.
`include "pesc_cfg.svh"

package pesc_pkg;

	// ----------------------------------------
	// Status inputs carried together
	// ----------------------------------------
	typedef struct packed {
		logic       pll_lock_flag;
		logic [3:0] polarity_flip;
		logic       refclk_freq_strap;
		logic [1:0] crossover_result;
		logic       speed_opt_link;
	} pesc_status_t;

	// ----------------------------------------
	// Read port request
	// ----------------------------------------
	typedef struct packed {
		logic                   rd;
		logic [`PESC_IDX_W-1:0] idx;
	} pesc_req_t;

	typedef enum logic [1:0] {
		PESC_SLICE_LOW,
		PESC_SLICE_MID,
		PESC_SLICE_HIGH,
		PESC_SLICE_NONE
	} pesc_slice_t;

endpackage

// *** hdl/pesc_bank.sv ***
// Advanced status and statistics register bank of the PHY core.
// Assumes status levels come from other clock domains, while frame
// events and the address port strobe share this core clock.
`timescale 1ns/10ps
`include "pesc_cfg.svh"

// Contract
// - Status one bit 15 reads 1 while PLL locked, else 0.
// - Status one bits 14..11 flag reversed polarity on channels 3..0.
// - Status one bit 8 shows strap clock: 0 is 125MHz, 1 is 25MHz.
// - Status two bit 15 shows pair 0/1 resolution: 0 MDI, 1 MDI-X.
// - Status two bit 14 shows pair 2/3 resolution: 0 MDI, 1 MDI-X.
// - Status two bit 13 set when speed optimizer brought link up; resets 0.
// - Keep 48-bit good frame counter, one per error-free frame, reset zero.
// - Good counter read as high 47:32, mid 31:16, low 15:0 slices.
// - High good slice read returns value then clears whole counter.
// - Keep 48-bit FCS failure counter in three slices, reset zero.
// - High FCS slice read returns value then clears whole counter.
module pesc_bank
	import pesc_pkg::*;
(
	input  wire logic                   MCLK_I,
	input  wire logic                   RESET_I,
	input  wire pesc_status_t           STATUS_I,
	input  wire logic                   GOOD_FRAME_I,
	input  wire logic                   FCS_FAIL_I,
	input  wire logic                   ADDR_WR_I,
	input  wire pesc_req_t              ADDR_REQ_I,
	output logic [`PESC_REG_W-1:0]      RD_DATA_O,
	output logic                        RD_VALID_O
);

	localparam int SW = $bits(pesc_status_t);

	// ----------------------------------------
	// Status synchronisers
	// ----------------------------------------
	// Three stages; a change is taken only once stages two and three agree
	logic [SW-1:0] sync_q [`PESC_SYNC_W];
	pesc_status_t  stat_q;

	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			for (int i = 0; i < `PESC_SYNC_W; i++) begin
				sync_q[i] <= '0;
			end
		end else begin
			sync_q[0] <= STATUS_I;
			for (int i = 1; i < `PESC_SYNC_W; i++) begin
				sync_q[i] <= sync_q[i-1];
			end
		end
	end

	genvar b;
	generate
		for (b = 0; b < SW; b++) begin : g_filt
			always_ff @(posedge MCLK_I) begin
				if (RESET_I) begin
					stat_q[b] <= 1'b0;
				end else if (sync_q[1][b] == sync_q[2][b]) begin
					stat_q[b] <= sync_q[2][b];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Address port decode
	// ----------------------------------------
	// Writes without the read flag select nothing; data port stays put
	logic        rd_go;
	pesc_slice_t good_sl;
	pesc_slice_t fcs_sl;

	assign rd_go = ADDR_WR_I && ADDR_REQ_I.rd;

	always_comb begin
		good_sl = PESC_SLICE_NONE;
		fcs_sl  = PESC_SLICE_NONE;
		if (rd_go) begin
			case (ADDR_REQ_I.idx)
				`PESC_IDX_GOOD_LOW:  good_sl = PESC_SLICE_LOW;
				`PESC_IDX_GOOD_MID:  good_sl = PESC_SLICE_MID;
				`PESC_IDX_GOOD_HIGH: good_sl = PESC_SLICE_HIGH;
				`PESC_IDX_FCS_LOW:   fcs_sl  = PESC_SLICE_LOW;
				`PESC_IDX_FCS_MID:   fcs_sl  = PESC_SLICE_MID;
				`PESC_IDX_FCS_HIGH:  fcs_sl  = PESC_SLICE_HIGH;
				default: begin
					good_sl = PESC_SLICE_NONE;
					fcs_sl  = PESC_SLICE_NONE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Counters
	// ----------------------------------------
	logic [`PESC_REG_W-1:0] good_slice;
	logic [`PESC_REG_W-1:0] fcs_slice;

	pesc_tally u_good (
		.clk_i      (MCLK_I),
		.rst_i      (RESET_I),
		.event_i    (GOOD_FRAME_I),
		.rd_slice_i (good_sl),
		.slice_o    (good_slice)
	);

	pesc_tally u_fcs (
		.clk_i      (MCLK_I),
		.rst_i      (RESET_I),
		.event_i    (FCS_FAIL_I),
		.rd_slice_i (fcs_sl),
		.slice_o    (fcs_slice)
	);

	// ----------------------------------------
	// Status words
	// ----------------------------------------
	logic [`PESC_REG_W-1:0] stat_one;
	logic [`PESC_REG_W-1:0] stat_two;

	always_comb begin
		stat_one = `PESC_REG_RESET;
		stat_one[`PESC_S1_PLL_BIT] = stat_q.pll_lock_flag;
		stat_one[`PESC_S1_POL_HI:`PESC_S1_POL_LO] = stat_q.polarity_flip;
		stat_one[`PESC_S1_REFCLK_BIT] = stat_q.refclk_freq_strap;
		stat_two = `PESC_REG_RESET;
		stat_two[`PESC_S2_XOVER01_BIT] = stat_q.crossover_result[0];
		stat_two[`PESC_S2_XOVER23_BIT] = stat_q.crossover_result[1];
		stat_two[`PESC_S2_SPDOPT_BIT]  = stat_q.speed_opt_link;
	end

	// ----------------------------------------
	// Read data port
	// ----------------------------------------
	// Counter slices land one cycle after the status word would, so the
	// selection is delayed to meet the tally's registered output
	logic [`PESC_IDX_W-1:0] idx_q;
	logic                   go_q;
	logic [`PESC_REG_W-1:0] stat_pick_q;

	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			idx_q       <= '0;
			go_q        <= 1'b0;
			stat_pick_q <= `PESC_REG_RESET;
		end else begin
			go_q  <= rd_go;
			if (rd_go) begin
				idx_q <= ADDR_REQ_I.idx;
				if (ADDR_REQ_I.idx == `PESC_IDX_STAT_ONE) begin
					stat_pick_q <= stat_one;
				end else begin
					stat_pick_q <= stat_two;
				end
			end
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			RD_DATA_O  <= `PESC_REG_RESET;
			RD_VALID_O <= 1'b0;
		end else begin
			RD_VALID_O <= go_q;
			if (go_q) begin
				case (idx_q)
					`PESC_IDX_STAT_ONE,
					`PESC_IDX_STAT_TWO:  RD_DATA_O <= stat_pick_q;
					`PESC_IDX_GOOD_LOW,
					`PESC_IDX_GOOD_MID,
					`PESC_IDX_GOOD_HIGH: RD_DATA_O <= good_slice;
					`PESC_IDX_FCS_LOW,
					`PESC_IDX_FCS_MID,
					`PESC_IDX_FCS_HIGH:  RD_DATA_O <= fcs_slice;
					default:             RD_DATA_O <= `PESC_REG_RESET;
				endcase
			end
		end
	end

endmodule

// *** hdl/pesc_tally.sv ***
// One 48-bit event tally with a low-read snapshot and a high-read clear.
// Assumes event and read strobes are one-cycle pulses on the same clock.
`timescale 1ns/10ps
`include "pesc_cfg.svh"

module pesc_tally
	import pesc_pkg::*;
#(
	parameter int CNT_W = `PESC_CNT_W,
	parameter int SL_W  = `PESC_REG_W
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              event_i,
	input  wire pesc_slice_t       rd_slice_i,
	output logic [SL_W-1:0]        slice_o
);

	// Read data is always three slices, so no other split can be served
	if (CNT_W != 3 * SL_W) begin : g_bad_width
		$error("pesc_tally: CNT_W must be three slices");
	end

	logic [CNT_W-1:0]  count_q;
	logic [2*SL_W-1:0] snap_q;
	logic [SL_W-1:0]   slice_q;

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	// An event in the cycle of a high read restarts the count at one,
	// so no frame is lost to the clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_q <= '0;
		end else if (rd_slice_i == PESC_SLICE_HIGH) begin
			count_q <= CNT_W'(event_i);
		end else if (event_i) begin
			count_q <= count_q + CNT_W'(1);
		end
	end

	// ----------------------------------------
	// Snapshot of upper slices at low read
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			snap_q <= '0;
		end else if (rd_slice_i == PESC_SLICE_LOW) begin
			snap_q <= count_q[CNT_W-1:SL_W];
		end
	end

	// ----------------------------------------
	// Registered read data
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slice_q <= '0;
		end else begin
			case (rd_slice_i)
				PESC_SLICE_LOW:  slice_q <= count_q[SL_W-1:0];
				PESC_SLICE_MID:  slice_q <= snap_q[SL_W-1:0];
				PESC_SLICE_HIGH: slice_q <= snap_q[2*SL_W-1:SL_W];
				default:         slice_q <= slice_q;
			endcase
		end
	end

	assign slice_o = slice_q;

endmodule

// *** verification/pesc_bank_props.sv ***
// Port checker for the status and statistics register bank.
// Assumes a bind to pesc_bank, one clock and a synchronous reset.
`timescale 1ns/10ps
module pesc_bank_props
	import pesc_pkg::*;
(
	input wire logic         MCLK_I,
	input wire logic         RESET_I,
	input wire pesc_status_t STATUS_I,
	input wire logic         GOOD_FRAME_I,
	input wire logic         FCS_FAIL_I,
	input wire logic         ADDR_WR_I,
	input wire pesc_req_t    ADDR_REQ_I,
	input wire logic [15:0]  RD_DATA_O,
	input wire logic         RD_VALID_O
);
	pesc_status_t s;
	logic         rq;
	logic [3:0]   ix;
	logic [15:0]  w1;
	logic [15:0]  w2;
	assign s = STATUS_I;
	assign rq = ADDR_WR_I & ADDR_REQ_I.rd;
	assign ix = ADDR_REQ_I.idx;
	assign w1 = {s.pll_lock_flag, s.polarity_flip, 2'h0, s.refclk_freq_strap, 8'h00};
	assign w2 = {s.crossover_result[0], s.crossover_result[1], s.speed_opt_link, 13'h0000};
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (RESET_I);
	// Status must settle through the synchroniser first
	a_stat_one: assert property ($stable(s)[*6] ##1 (rq && ix == 4'h0 && $stable(s)) ##1
		$stable(s)[*2] |-> RD_DATA_O == w1) else $error("status one word wrong");
	a_stat_two: assert property ($stable(s)[*6] ##1 (rq && ix == 4'h1 && $stable(s)) ##1
		$stable(s)[*2] |-> RD_DATA_O == w2) else $error("status two word wrong");
	a_answer_lat: assert property (rq |-> ##2 RD_VALID_O)
		else $error("answer missing");
	a_no_stray: assert property (RD_VALID_O |-> $past(rq, 2))
		else $error("answer without request");
	a_good_step: assert property (rq && ix == 4'h4 ##1 rq && ix == 4'h4 |-> ##2
		RD_DATA_O == $past(RD_DATA_O) + 16'($past(GOOD_FRAME_I, 3))) else $error("good step");
	a_fcs_step: assert property (rq && ix == 4'h7 ##1 rq && ix == 4'h7 |-> ##2
		RD_DATA_O == $past(RD_DATA_O) + 16'($past(FCS_FAIL_I, 3))) else $error("fcs step");
	a_good_clear: assert property (rq && ix == 4'h2 ##1 rq && ix == 4'h4 |-> ##2
		RD_DATA_O == 16'($past(GOOD_FRAME_I, 3))) else $error("good counter not cleared");
	a_fcs_clear: assert property (rq && ix == 4'h5 ##1 rq && ix == 4'h7 |-> ##2
		RD_DATA_O == 16'($past(FCS_FAIL_I, 3))) else $error("fcs counter not cleared");
endmodule

bind pesc_bank pesc_bank_props pesc_bank_props_inst (.MCLK_I(MCLK_I), .RESET_I(RESET_I),
	.STATUS_I(STATUS_I), .GOOD_FRAME_I(GOOD_FRAME_I), .FCS_FAIL_I(FCS_FAIL_I),
	.ADDR_WR_I(ADDR_WR_I), .ADDR_REQ_I(ADDR_REQ_I), .RD_DATA_O(RD_DATA_O),
	.RD_VALID_O(RD_VALID_O));

// *** verification/pesc_bank_tb.sv ***
// Self-checking bench for the status and statistics register bank.
// Assumes the checker binds itself; inputs change on falling edges.
`timescale 1ns/10ps
module pesc_bank_tb;
	import pesc_pkg::*;
	logic         mclk;
	logic         rst = 1'b1;
	pesc_status_t status = '0;
	logic         good = 1'b0;
	logic         fcs = 1'b0;
	logic         wr = 1'b0;
	pesc_req_t    req = '0;
	logic [15:0]  rd_data;
	logic         rd_valid;
	int           mismatches = 0;
	int           cmp_count = 0;
	int           cyc = 0;

	pesc_bank pesc_bank_inst (.MCLK_I(mclk), .RESET_I(rst), .STATUS_I(status),
		.GOOD_FRAME_I(good), .FCS_FAIL_I(fcs), .ADDR_WR_I(wr), .ADDR_REQ_I(req),
		.RD_DATA_O(rd_data), .RD_VALID_O(rd_valid));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// Longest test is the counter fill of about 65600 cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 80000) begin
			mismatches++;
			complete_run();
		end
	end

	task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
		cmp_count++;
		if (g !== x) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, x, g);
		end
	endtask

	// Two reads back to back; e pulses both events with the first
	task automatic pr(input logic [3:0] a, input logic [3:0] b, input logic e,
		input logic [15:0] xa, input logic [15:0] xb);
		int k;
		@(negedge mclk);
		wr = 1'b1;
		req = {1'b1, a};
		good = e;
		fcs = e;
		@(negedge mclk);
		req = {1'b1, b};
		good = 1'b0;
		fcs = 1'b0;
		@(negedge mclk);
		wr = 1'b0;
		k = 0;
		while (rd_valid !== 1'b1 && k < 8) begin
			@(negedge mclk);
			k++;
		end
		chk("RD_VALID_O", 16'h0001, {15'h0000, rd_valid});
		chk("RD_DATA_O", xa, rd_data);
		@(negedge mclk);
		chk("RD_VALID_O", 16'h0001, {15'h0000, rd_valid});
		chk("RD_DATA_O", xb, rd_data);
	endtask

	task automatic t_reset;
		for (int i = 0; i < 10; i += 2) begin
			pr(4'(i), 4'(i + 1), 1'b0, 16'h0000, 16'h0000);
		end
		$display("t_reset done");
	endtask

	task automatic t_status;
		status = 9'h1AD;
		repeat (8) @(negedge mclk);
		pr(4'h0, 4'h1, 1'b0, 16'hD100, 16'h6000);
		// Hold the word one more cycle so the status two check sees it settled
		@(negedge mclk);
		status = 9'h052;
		repeat (8) @(negedge mclk);
		pr(4'h0, 4'h1, 1'b0, 16'h2800, 16'h8000);
		$display("t_status done");
	endtask

	task automatic t_refuse;
		@(negedge mclk);
		wr = 1'b1;
		req = {1'b0, 4'h4};
		@(negedge mclk);
		wr = 1'b0;
		repeat (4) begin
			@(negedge mclk);
			chk("RD_VALID_O", 16'h0000, {15'h0000, rd_valid});
		end
		$display("t_refuse done");
	endtask

	task automatic t_count;
		for (int i = 0; i < 65538; i++) begin
			@(negedge mclk);
			good = 1'b1;
			fcs = (i < 65535);
		end
		@(negedge mclk);
		good = 1'b0;
		fcs = 1'b0;
		pr(4'h7, 4'h6, 1'b1, 16'hFFFF, 16'h0000);
		pr(4'h5, 4'h7, 1'b0, 16'h0000, 16'h0000);
		pr(4'h4, 4'h4, 1'b1, 16'h0003, 16'h0004);
		pr(4'h3, 4'h2, 1'b0, 16'h0001, 16'h0000);
		pr(4'h2, 4'h4, 1'b1, 16'h0000, 16'h0001);
		pr(4'h7, 4'h7, 1'b1, 16'h0002, 16'h0003);
		$display("t_count done");
	endtask

	task automatic complete_run;
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		repeat (8) @(negedge mclk);
		rst = 1'b0;
		t_reset();
		t_status();
		t_refuse();
		t_count();
		complete_run();
	end
endmodule
